// file: rtl/vpic_arb.sv
`timescale 1ns/1ns
`default_nettype none
module vpic_arb
  import vpic_pkg::*;
(
  vpic_arb_if.arb a
);
  logic [PW-1:0] best;

  // descending scan with <= so the lowest index wins a tie
  always_comb
  begin
    a.found = 1'b0;
    a.vec   = '0;
    best    = PRIO_LOW;
    for (int v = NVEC - 1; v >= 0; v--)
    begin
      if (a.cand[v] && (!a.ceil_on || a.prio[v] < a.ceil) &&
          (!a.found || a.prio[v] <= best))
      begin
        a.found = 1'b1;
        best    = a.prio[v];
        a.vec   = VW'(v);
      end
    end
  end
endmodule : vpic_arb
`default_nettype wire

// file: rtl/vpic_arb_if.sv
`timescale 1ns/1ns
`default_nettype none
interface vpic_arb_if
  import vpic_pkg::*;
();
  logic [NVEC-1:0]         cand;
  logic [NVEC-1:0][PW-1:0] prio;
  logic                    ceil_on;
  logic [PW-1:0]           ceil;
  logic                    found;
  logic [VW-1:0]           vec;

  modport req (output cand, prio, ceil_on, ceil, input found, vec);
  modport arb (input cand, prio, ceil_on, ceil, output found, vec);
endinterface : vpic_arb_if
`default_nettype wire

// file: rtl/vpic_ctrl.sv
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module vpic_ctrl
  import vpic_pkg::*;
(
  input  wire logic           i_clk,
  input  wire logic           i_sys_rst,
  input  wire logic [RAW-1:0] i_addr,
  input  wire logic [DW-1:0]  i_wdata,
  input  wire logic           i_wr,
  input  wire logic           i_rd,
  output var  logic [DW-1:0]  o_rdata,
  input  wire logic [NSRC-1:0] i_src,
  input  wire logic [NPORT-1:0] i_port_irq,
  output var  logic           o_irq,
  output var  logic [VW-1:0]  o_irq_num,
  output var  logic [AW-1:0]  o_handler_addr,
  input  wire logic           i_core_irq_acknowledge,
  input  wire logic           i_handler_complete
);

  typedef struct packed {
    logic [NVEC-1:0]               en;
    logic [NVEC-1:0]               pending_flag;
    logic [NVEC-1:0]               posted_flag;
    logic [NVEC-1:0][AW-1:0]       addr;
    logic [NVEC-1:0][PW-1:0]       prio;
    logic [NSRC-1:0][VW-1:0]       map;
    logic [NSRC-1:0]               src_q;
    logic [NPORT-1:0]              port_q;
    logic [NEST-1:0][VW+PW-1:0]    stk;
    logic [DEPW-1:0]               depth;
    vpic_st_e                      st;
    logic [VW-1:0]                 win;
    logic                          irq;
    logic [VW-1:0]                 irq_num;
    logic [AW-1:0]                 haddr;
    logic [DW-1:0]                 rdata;
  } vpic_state_s;

  vpic_state_s     r;
  vpic_state_s     n;
  logic [NVEC-1:0] hw;
  logic [NVEC-1:0] sw_set;
  logic [NVEC-1:0] clr;
  vpic_frame_s     tos;
  vpic_frame_s     newf;
  logic            push;
  logic            pop;

  vpic_arb_if arb_if ();

  vpic_arb u_arb (
    .a (arb_if)
  );

  // top of the nesting stack holds the level being serviced
  assign tos = vpic_frame_s'(r.stk[SPW'(r.depth - DEPTH_ONE)]);

  // only enabled posted vectors compete; a full stack blocks all
  assign arb_if.cand    = (r.depth == DEPTH_FULL) ? '0 :
                          (r.posted_flag & r.en);
  assign arb_if.prio    = r.prio;
  assign arb_if.ceil_on = (r.depth != '0);
  assign arb_if.ceil    = tos.prio;

  assign push = (r.st == ST_REQ) && i_core_irq_acknowledge;
  assign pop  = i_handler_complete && (r.depth != '0);

  always_comb
  begin
    n      = r;
    hw     = '0;
    sw_set = '0;
    clr    = '0;
    newf   = '{vec: r.win, prio: r.prio[r.win]};
    n.src_q  = i_src;
    n.port_q = i_port_irq;
    n.rdata  = '0;

    // rising edges of mapped sources; several may share one vector
    for (int s = 0; s < NSRC; s++)
    begin
      if (i_src[s] && !r.src_q[s])
        hw[r.map[s]] = 1'b1;
    end
    // port lines are wired to their own vectors, no remapping
    for (int p = 0; p < NPORT; p++)
    begin
      if (i_port_irq[p] && !r.port_q[p])
        hw[IO_VEC_BASE + p] = 1'b1;
    end

    // register writes
    if (i_wr)
    begin
      if (i_addr == REG_ENABLE)
        n.en = i_wdata;
      else if (i_addr == REG_PENDING_FLAG_SET)
        sw_set = i_wdata;
      else if (i_addr == REG_PENDING_FLAG_CLR)
        clr = i_wdata;
      else if ((i_addr & REG_VEC_MASK) == REG_VEC_BASE)
      begin
        n.addr[i_addr[VW-1:0]] = i_wdata[AW-1:0];
        n.prio[i_addr[VW-1:0]] = i_wdata[VEC_PRIO_LSB +: PW];
      end
      else if ((i_addr & REG_MAP_MASK) == REG_MAP_BASE)
        n.map[i_addr[SW-1:0]] = i_wdata[VW-1:0];
    end

    // acknowledge retires the winner's pending flag
    if (push)
      clr[r.win] = 1'b1;

    // a new arrival in the clearing cycle is kept: set wins
    n.pending_flag = (r.pending_flag & ~clr) | hw | sw_set;
    // posted trails pending by one cycle, so it also clears a cycle later
    n.posted_flag  = r.pending_flag;

    // request handshake
    case (r.st)
      ST_IDLE:
      begin
        // one evaluation edge after posted: pending, posted and request
        // take three clocks, so the path with the core stays at twelve
        if (arb_if.found)
        begin
          n.win     = arb_if.vec;
          n.irq     = 1'b1;
          n.irq_num = arb_if.vec;
          n.haddr   = r.addr[arb_if.vec];
          n.st      = ST_REQ;
        end
      end
      ST_REQ:
      begin
        if (i_core_irq_acknowledge)
        begin
          n.irq = 1'b0;
          n.st  = ST_ACK;
        end
        else if (!(r.posted_flag[r.win] && r.pending_flag[r.win] &&
                   r.en[r.win]))
        begin
          // cancelled by software before service: withdraw
          n.irq = 1'b0;
          n.st  = ST_IDLE;
        end
      end
      ST_ACK:
      begin
        // the core holds acknowledge while it branches
        if (!i_core_irq_acknowledge)
          n.st = ST_IDLE;
      end
      default:
      begin
        n.irq = 1'b0;
        n.st  = ST_IDLE;
      end
    endcase

    // active stack; push and pop together replace the top entry
    if (push && pop)
      n.stk[SPW'(r.depth - DEPTH_ONE)] = newf;
    else if (push)
    begin
      n.stk[SPW'(r.depth)] = newf;
      n.depth              = r.depth + DEPTH_ONE;
    end
    else if (pop)
      n.depth = r.depth - DEPTH_ONE;

    // read data stands only in the cycle after the strobe
    if (i_rd)
    begin
      if (i_addr == REG_ENABLE)
        n.rdata = r.en;
      else if (i_addr == REG_PENDING_FLAG_SET)
        n.rdata = r.pending_flag;
      else if (i_addr == REG_PENDING_FLAG_CLR)
        n.rdata = r.posted_flag;
      else if (i_addr == REG_ACTIVE)
      begin
        n.rdata[ACT_DEPTH_LSB +: DEPW] = r.depth;
        n.rdata[VW-1:0] = (r.depth != '0) ? tos.vec : '0;
      end
      else if ((i_addr & REG_VEC_MASK) == REG_VEC_BASE)
      begin
        n.rdata[AW-1:0] = r.addr[i_addr[VW-1:0]];
        n.rdata[VEC_PRIO_LSB +: PW] = r.prio[i_addr[VW-1:0]];
      end
      else if ((i_addr & REG_MAP_MASK) == REG_MAP_BASE)
        n.rdata[VW-1:0] = r.map[i_addr[SW-1:0]];
    end
  end

  // single state register; priorities reset to the lowest level
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      r      <= '0;
      r.prio <= {NVEC{PRIO_RST}};
    end
    else
      r <= n;
  end

  assign o_rdata        = r.rdata;
  assign o_irq          = r.irq;
  assign o_irq_num      = r.irq_num;
  assign o_handler_addr = r.haddr;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_arrive;
    (r.st == ST_IDLE) && arb_if.found;
  endsequence

  sequence s_request;
    o_irq && (o_irq_num == $past(arb_if.vec));
  endsequence

  sequence s_ack_clean;
    push && !hw[r.win] && !sw_set[r.win];
  endsequence

  a_pending_flag_capture: assert property (
    (hw != '0) |=> ((r.pending_flag & $past(hw)) == $past(hw)))
    else $error("hardware arrival did not set pending");

  a_posted_flag_follow: assert property (
    (r.pending_flag != '0) |=>
    ((r.posted_flag & $past(r.pending_flag)) == $past(r.pending_flag)))
    else $error("posted did not follow pending");

  a_eval_three: assert property (
    s_arrive |=> s_request)
    else $error("request not raised after evaluation");

  a_ack_clears: assert property (
    s_ack_clean |=> !r.pending_flag[$past(r.win)]
    ##1 !r.posted_flag[$past(r.win, 2)])
    else $error("acknowledge did not clear pending then posted");

  a_irq_enabled: assert property (
    $rose(o_irq) |-> r.en[o_irq_num] && r.posted_flag[o_irq_num])
    else $error("request for a disabled or unposted vector");

  a_prio_preempt: assert property (
    $rose(o_irq) |-> (r.depth == '0) || (r.prio[o_irq_num] < tos.prio))
    else $error("request does not preempt current level");

  a_nest_push: assert property (
    (push && !pop) |=> (r.depth == $past(r.depth) + DEPTH_ONE)
    && (r.depth <= DEPTH_FULL))
    else $error("nesting depth not advanced on acknowledge");

  a_nest_pop: assert property (
    (pop && !push) |=> (r.depth == $past(r.depth) - DEPTH_ONE))
    else $error("completion did not restore previous level");

  a_sw_raise: assert property (
    (i_wr && (i_addr == REG_PENDING_FLAG_SET)) |=>
    ((r.pending_flag & $past(i_wdata)) == $past(i_wdata)))
    else $error("software raise lost");

  a_sw_cancel: assert property (
    (i_wr && (i_addr == REG_PENDING_FLAG_CLR))
    |=> ((r.pending_flag & $past(i_wdata) & ~$past(hw)) == '0)
    ##1 ((r.posted_flag & $past(i_wdata, 2) & ~$past(hw, 2)) == '0))
    else $error("software clear did not cancel");

  a_addr_stable: assert property (
    (o_irq && !i_core_irq_acknowledge) |=> $stable(o_handler_addr))
    else $error("handler address moved while requesting");

  a_irq_drop: assert property (
    (o_irq && i_core_irq_acknowledge) |=> !o_irq)
    else $error("request still up after acknowledge");

  a_port_route: assert property (
    ((i_port_irq & ~r.port_q) != '0) |=>
    ((r.pending_flag[IO_VEC_BASE +: NPORT] &
      $past(i_port_irq & ~r.port_q)) == $past(i_port_irq & ~r.port_q)))
    else $error("port line did not reach its vector");

endmodule : vpic_ctrl
`default_nettype wire

// file: rtl/vpic_pkg.sv
package vpic_pkg;

  // sizes
  localparam int NVEC  = 32;  // interrupt vectors
  localparam int NSRC  = 16;  // remappable hardware sources
  localparam int NPORT = 4;   // i/o port interrupt lines
  localparam int VW    = 5;   // vector number width
  localparam int PW    = 3;   // priority width, eight levels, 0 highest
  localparam int AW    = 16;  // handler address width
  localparam int SW    = 4;   // source index width
  localparam int NEST  = 8;   // nesting depth
  localparam int DEPW  = 4;   // depth counter width
  localparam int SPW   = 3;   // stack index width
  localparam int RAW   = 8;   // register address width
  localparam int DW    = 32;  // register data width

  // i/o port lines land on the top vectors, one each
  localparam int IO_VEC_BASE = 28;

  // register map, word addresses
  localparam logic [RAW-1:0] REG_ENABLE   = 8'h00;
  localparam logic [RAW-1:0] REG_PENDING_FLAG_SET = 8'h01;
  localparam logic [RAW-1:0] REG_PENDING_FLAG_CLR = 8'h02;
  localparam logic [RAW-1:0] REG_ACTIVE   = 8'h03;
  localparam logic [RAW-1:0] REG_VEC_BASE = 8'h20;
  localparam logic [RAW-1:0] REG_VEC_MASK = 8'hE0;
  localparam logic [RAW-1:0] REG_MAP_BASE = 8'h40;
  localparam logic [RAW-1:0] REG_MAP_MASK = 8'hF0;

  // field positions
  localparam int VEC_PRIO_LSB  = 16;
  localparam int ACT_DEPTH_LSB = 8;

  // reset priority, lowest priority and depth constants
  localparam logic [PW-1:0]   PRIO_RST   = 3'h7;
  localparam logic [PW-1:0]   PRIO_LOW   = 3'h7;
  localparam logic [DEPW-1:0] DEPTH_FULL = 4'h8;
  localparam logic [DEPW-1:0] DEPTH_ONE  = 4'h1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_ACK
  } vpic_st_e;

  typedef struct packed {
    logic [VW-1:0] vec;
    logic [PW-1:0] prio;
  } vpic_frame_s;

endpackage : vpic_pkg

// file: verif/tb_vpic_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module tb_vpic_ctrl
  import vpic_pkg::*;
;
  logic             i_clk;
  logic             i_sys_rst;
  logic [RAW-1:0]   i_addr;
  logic [DW-1:0]    i_wdata;
  logic             i_wr;
  logic             i_rd;
  logic [DW-1:0]    o_rdata;
  logic [NSRC-1:0]  i_src;
  logic [NPORT-1:0] i_port_irq;
  logic             o_irq;
  logic [VW-1:0]    o_irq_num;
  logic [AW-1:0]    o_handler_addr;
  logic             irq_ack;
  logic             hdl_done;
  logic             slow;
  logic             got;
  logic [VW-1:0]    got_num;
  logic [AW-1:0]    got_addr;
  logic             rd_p1;
  logic [AW-1:0]    ha [NVEC];
  logic [15:0]      lfsr;
  logic [DW-1:0]    rq [$];
  logic [VW+AW-1:0] iq [$];
  int               fails;
  int               samples_checked;

  vpic_ctrl vpic_ctrl_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_src(i_src), .i_port_irq(i_port_irq),
    .o_irq(o_irq), .o_irq_num(o_irq_num),
    .o_handler_addr(o_handler_addr),
    .i_core_irq_acknowledge(irq_ack), .i_handler_complete(hdl_done));

  vpic_core_model vpic_core_model_i (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_slow(slow), .i_irq(o_irq),
    .i_num(o_irq_num), .i_addr(o_handler_addr), .o_ack(irq_ack),
    .o_got(got), .o_got_num(got_num), .o_got_addr(got_addr));

  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  function automatic logic [15:0] lf(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lf

  // vectors 1..8 climb one level each so every one can preempt
  function automatic logic [PW-1:0] pr(input int v);
    if (v >= 1 && v <= 8)
      return PW'(8 - v);
    if (v == 10)
      return 3'h5;
    return (v == 12 || v == 20) ? 3'h2 : PRIO_LOW;
  endfunction : pr

  task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [RAW-1:0] a, input logic [DW-1:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [RAW-1:0] a, input logic [DW-1:0] e);
    rq.push_back(e);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask : rd

  task automatic cpl();
    @(posedge i_clk);
    hdl_done <= 1'b1;
    @(posedge i_clk);
    hdl_done <= 1'b0;
  endtask : cpl

  // bounded wait for one acknowledge to come and go
  task automatic serve(input bit done_too);
    int k;
    k = 0;
    while (!irq_ack && k < 40)
    begin
      @(negedge i_clk);
      k++;
    end
    chk(DW'(irq_ack), 32'h1);
    while (irq_ack && k < 60)
    begin
      @(negedge i_clk);
      k++;
    end
    chk(DW'(irq_ack), 32'h0);
    if (done_too)
      cpl();
  endtask : serve

  task automatic trig(input bit port, input int idx, input int v);
    int k;
    iq.push_back({VW'(v), ha[v]});
    @(posedge i_clk);
    if (port)
      i_port_irq <= NPORT'(1 << idx);
    else
      i_src <= NSRC'(1 << idx);
    k = 0;
    @(negedge i_clk);
    while (!o_irq && k < 20)
    begin
      @(negedge i_clk);
      k++;
    end
    chk(DW'(k), 32'h3);
    @(posedge i_clk);
    i_src      <= 16'h0;
    i_port_irq <= 4'h0;
    serve(1'b1);
  endtask : trig

  // results are compared in arrival order against the noted values
  always @(posedge i_clk)
  begin
    rd_p1 <= i_rd;
    if (rd_p1)
      chk(o_rdata, rq.size() ? rq.pop_front() : '1);
    if (got)
      chk(DW'({got_num, got_addr}), iq.size() ? DW'(iq.pop_front()) : '1);
  end

  // under 500 cycles expected; 30000 cycles means a hang
  initial
  begin
    #300000;
    fails++;
    end_sim();
  end

  initial
  begin
    i_sys_rst  = 1'b1;
    i_addr     = 8'h0;
    i_wdata    = 32'h0;
    i_wr       = 1'b0;
    i_rd       = 1'b0;
    i_src      = 16'h0;
    i_port_irq = 4'h0;
    hdl_done   = 1'b0;
    slow       = 1'b0;
    rd_p1      = 1'b0;
    lfsr       = 16'hBBCA;
    fails      = 0;
    samples_checked = 0;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(REG_ENABLE, 32'h0);
    rd(REG_ACTIVE, 32'h0);
    rd(REG_VEC_BASE, 32'h0007_0000);
    rd(8'h10, 32'h0);
    $display("test reset values done");
    for (int v = 0; v < NVEC; v++)
    begin
      lfsr = lf(lfsr);
      ha[v] = lfsr;
      wr(REG_VEC_BASE | RAW'(v), {13'h0, pr(v), ha[v]});
    end
    rd(REG_VEC_BASE | 8'h0C, {13'h0, 3'h2, ha[12]});
    wr(REG_ENABLE, 32'hFFFF_FFFF);
    for (int s = 5; s < 8; s++)
      wr(REG_MAP_BASE | RAW'(s), 32'h9);
    rd(REG_MAP_BASE | 8'h05, 32'h9);
    for (int s = 5; s < 8; s++)
      trig(1'b0, s, 9);
    rd(REG_PENDING_FLAG_SET, 32'h0);
    rd(REG_PENDING_FLAG_CLR, 32'h0);
    $display("test sources done");
    wr(REG_PENDING_FLAG_SET, 32'h0010_1400);
    iq.push_back({5'h0C, ha[12]});
    iq.push_back({5'h14, ha[20]});
    iq.push_back({5'h0A, ha[10]});
    repeat (3) serve(1'b1);
    $display("test priority done");
    wr(REG_ENABLE, 32'hFDFF_FFFF);
    wr(REG_PENDING_FLAG_SET, 32'h0200_0000);
    repeat (10) @(negedge i_clk);
    chk(DW'(o_irq), 32'h0);
    rd(REG_PENDING_FLAG_SET, 32'h0200_0000);
    wr(REG_PENDING_FLAG_CLR, 32'h0200_0000);
    rd(REG_PENDING_FLAG_SET, 32'h0);
    wr(REG_ENABLE, 32'hFFFF_FFFF);
    repeat (10) @(negedge i_clk);
    chk(DW'(o_irq), 32'h0);
    $display("test clear done");
    slow <= 1'b1;
    // a request cancelled before the slow core answers is withdrawn
    wr(REG_PENDING_FLAG_SET, 32'h0000_0800);
    wr(REG_PENDING_FLAG_CLR, 32'h0000_0800);
    @(negedge i_clk);
    chk(DW'(o_irq), 32'h1);
    repeat (10) @(negedge i_clk);
    chk(DW'(o_irq), 32'h0);
    for (int v = 1; v <= NEST; v++)
    begin
      iq.push_back({VW'(v), ha[v]});
      wr(REG_PENDING_FLAG_SET, 32'h1 << v);
      serve(1'b0);
    end
    rd(REG_ACTIVE, 32'h0000_0808);
    cpl();
    rd(REG_ACTIVE, 32'h0000_0707);
    repeat (7) cpl();
    rd(REG_ACTIVE, 32'h0);
    slow <= 1'b0;
    $display("test nesting done");
    for (int p = 0; p < NPORT; p++)
      trig(1'b1, p, IO_VEC_BASE + p);
    $display("test port lines done");
    repeat (5) @(posedge i_clk);
    chk(DW'(iq.size() + rq.size()), 32'h0);
    end_sim();
  end
endmodule : tb_vpic_ctrl
`default_nettype wire

// file: verif/vpic_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module vpic_core_model
  import vpic_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_sys_rst,
  input  wire logic          i_slow,
  input  wire logic          i_irq,
  input  wire logic [VW-1:0] i_num,
  input  wire logic [AW-1:0] i_addr,
  output var  logic          o_ack,
  output var  logic          o_got,
  output var  logic [VW-1:0] o_got_num,
  output var  logic [AW-1:0] o_got_addr
);
  logic [3:0] wait_r;
  logic [3:0] hold_r;

  // slow mode leaves the request standing three extra cycles
  always @(posedge i_clk)
  begin
    o_got <= 1'b0;
    if (i_sys_rst)
    begin
      o_ack  <= 1'b0;
      wait_r <= 4'h0;
      hold_r <= 4'h0;
    end
    else if (o_ack)
    begin
      hold_r <= hold_r + 4'h1;
      if (hold_r == 4'h0)
      begin
        o_got      <= 1'b1;
        o_got_num  <= i_num;
        o_got_addr <= i_addr;
      end
      if (hold_r == 4'h6)
        o_ack <= 1'b0;
    end
    else if (i_irq && (!i_slow || wait_r == 4'h3))
    begin
      o_ack  <= 1'b1;
      hold_r <= 4'h0;
      wait_r <= 4'h0;
    end
    else
      wait_r <= i_irq ? wait_r + 4'h1 : 4'h0;
  end
endmodule : vpic_core_model
`default_nettype wire
